/* File: design/hif_core.sv */
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - four interrupt registers: main, timer, error, target
// - event sets bit; unmasked bit raises irq
// - reading interrupt register returns then clears it
// - irq falls once all causing bits read
// - masked source records bit, irq stays low
// - masked bits read and cleared likewise
// - unmasking a set bit raises irq at once
// - commands and status read clear irq bits
// - 512-byte fifo between host and framing
// - overflow flag when pushing into full fifo
// - underflow flag when popping an empty fifo
// - fifo reset at rx start, reset, set-default and clear-fifo commands
// - reading empty fifo returns zero
// - two-bit select enables and divides clock output
// - disable bit gates 32 kHz clock output
// - power-up default 3.39 MHz, low clock on
// - strap low selects SPI, high I2C
module hif_core import hif_pkg::*; #(
  parameter int FIFO_DEPTH = HIF_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [HIF_AW-1:0] reg_addr,
  input wire logic [HIF_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [HIF_DW-1:0] reg_rdata,
  input wire hif_irq_vec_t irq_events,
  output logic irq,
  input wire logic rx_start,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_pop,
  output logic [7:0] tx_data,
  output logic stop_all,
  input wire logic xtal_running,
  input wire logic [HIF_NPINS-2:0] osc_clk_pins,
  input wire logic i2c_en_pin,
  output logic host_port_i2c,
  output logic mcu_clk
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);

  // ==========================================================
  // register decode
  wire logic [HIF_AW-1:0] irq_idx_addr = reg_addr - HIF_ADDR_IRQ_BASE;
  wire logic [HIF_AW-1:0] mask_idx_addr = reg_addr - HIF_ADDR_MASK_BASE;
  wire logic in_irq = reg_addr < HIF_ADDR_MASK_BASE;
  wire logic in_mask = (reg_addr >= HIF_ADDR_MASK_BASE) && (reg_addr < HIF_ADDR_FIFO_DATA);
  wire logic cmd_wr = reg_wr && (reg_addr == HIF_ADDR_CMD);
  wire logic cmd_default = cmd_wr && (reg_wdata == HIF_CMD_SET_DEFAULT);
  wire logic cmd_stop = cmd_wr && (reg_wdata == HIF_CMD_STOP_ALL);
  wire logic cmd_clrfifo = cmd_wr && (reg_wdata == HIF_CMD_CLEAR_FIFO);
  wire logic irq_clear_all = cmd_default || cmd_stop || cmd_clrfifo;
  wire logic cfg_wr = reg_wr && (reg_addr == HIF_ADDR_IO_CFG1);
  wire logic fifo_host_wr = reg_wr && (reg_addr == HIF_ADDR_FIFO_DATA);
  wire logic fifo_host_rd = reg_rd && (reg_addr == HIF_ADDR_FIFO_DATA);

  // ==========================================================
  // interrupt status and mask registers
  logic [7:0] stat [4];
  logic [7:0] mask [4];
  logic [3:0] pend;
  wire logic [7:0] ev [4];
  assign ev[0] = irq_events.main;
  assign ev[1] = irq_events.timer;
  assign ev[2] = irq_events.err;
  assign ev[3] = irq_events.pt;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_irq
      wire logic rd_hit = reg_rd && in_irq && (irq_idx_addr == HIF_AW'(gi));
      wire logic wr_mask = reg_wr && in_mask && (mask_idx_addr == HIF_AW'(gi));
      // a new event in the clearing cycle survives: set wins over clear
      wire logic [7:0] next_stat = ((rd_hit || irq_clear_all) ? 8'h00 : stat[gi]) | ev[gi];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stat[gi] <= HIF_STAT_RST;
          mask[gi] <= HIF_MASK_RST;
        end else begin
          stat[gi] <= next_stat;
          if (wr_mask) begin
            mask[gi] <= reg_wdata;
          end
        end
      end
      assign pend[gi] = |(stat[gi] & ~mask[gi]);
    end
  endgenerate

  // irq follows pending unmasked bits, so unmasking an old bit raises it too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |pend;
    end
  end

  // ==========================================================
  // fifo storage and pointers
  logic [7:0] mem [FIFO_DEPTH];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [CW-1:0] count;
  logic ovr;
  logic unf;
  wire logic fifo_reset = rx_start || cmd_default || cmd_clrfifo;
  wire logic empty = (count == '0);
  wire logic full = (count == FULL_CNT);
  wire logic push_req = fifo_host_wr || rx_valid;
  wire logic pop_req = fifo_host_rd || tx_pop;
  wire logic do_push = push_req && !full && !fifo_reset;
  wire logic do_pop = pop_req && !empty && !fifo_reset;
  // receive data takes the slot if the host writes in the same cycle
  wire logic [7:0] push_data = rx_valid ? rx_data : reg_wdata;
  wire logic [7:0] head = empty ? 8'h00 : mem[rptr];
  wire logic [PW-1:0] next_wptr = (wptr == PW'(FIFO_DEPTH - 1)) ? '0 : wptr + 1'b1;
  wire logic [PW-1:0] next_rptr = (rptr == PW'(FIFO_DEPTH - 1)) ? '0 : rptr + 1'b1;
  wire logic [CW-1:0] next_count = count + CW'(do_push) - CW'(do_pop);

  // storage has no reset so it maps to a ram
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wptr] <= push_data;
    end
  end

  // pointers, level and sticky error flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      ovr <= 1'b0;
      unf <= 1'b0;
    end else if (fifo_reset) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      ovr <= 1'b0;
      unf <= 1'b0;
    end else begin
      if (do_push) begin
        wptr <= next_wptr;
      end
      if (do_pop) begin
        rptr <= next_rptr;
      end
      count <= next_count;
      ovr <= ovr || (push_req && full);
      unf <= unf || (pop_req && empty);
    end
  end

  // byte handed to the framing logic, zero when nothing was loaded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data <= 8'h00;
    end else if (tx_pop) begin
      tx_data <= head;
    end
  end

  // ==========================================================
  // clock output configuration
  logic [7:0] cfg1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg1 <= HIF_CFG1_RST;
    end else if (cmd_default) begin
      cfg1 <= HIF_CFG1_RST;
    end else if (cfg_wr) begin
      cfg1 <= reg_wdata;
    end
  end
  wire hif_clk_sel_t clk_sel = hif_clk_sel_t'(cfg1[HIF_CFG1_OUTC_LSB +: 2]);
  wire logic low_freq_clock_disable = cfg1[HIF_CFG1_LFOFF_BIT];

  // ==========================================================
  // pin synchronisers: a change counts once stages two and three agree
  logic [HIF_NPINS-1:0] s1;
  logic [HIF_NPINS-1:0] s2;
  logic [HIF_NPINS-1:0] s3;
  logic [HIF_NPINS-1:0] pin_f;
  wire logic [HIF_NPINS-1:0] pin_raw = {i2c_en_pin, osc_clk_pins};
  generate
    for (gi = 0; gi < HIF_NPINS; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
          s3[gi] <= 1'b0;
          pin_f[gi] <= 1'b0;
        end else begin
          s1[gi] <= pin_raw[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) begin
            pin_f[gi] <= s3[gi];
          end
        end
      end
    end
  endgenerate

  // sampled oscillator phases are coarse at this rate: the faster taps alias,
  // a true divider belongs on the crystal clock itself
  logic xtal_tap;
  always_comb begin
    unique case (clk_sel)
      HIF_CLK_OFF: xtal_tap = 1'b0;
      HIF_CLK_3M39: xtal_tap = pin_f[HIF_PIN_3M39];
      HIF_CLK_6M78: xtal_tap = pin_f[HIF_PIN_6M78];
      HIF_CLK_13M56: xtal_tap = pin_f[HIF_PIN_13M56];
    endcase
  end
  wire logic lf_tap = (clk_sel != HIF_CLK_OFF) && !low_freq_clock_disable && pin_f[HIF_PIN_LF];
  wire logic next_mcu_clk = xtal_running ? xtal_tap : lf_tap;

  // ==========================================================
  // read data, output flops and command strobe
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (in_irq) begin
      rd_mux = stat[irq_idx_addr[1:0]];
    end else if (in_mask) begin
      rd_mux = mask[mask_idx_addr[1:0]];
    end else if (reg_addr == HIF_ADDR_FIFO_DATA) begin
      rd_mux = head;
    end else if (reg_addr == HIF_ADDR_FIFO_STAT1) begin
      rd_mux = count[7:0];
    end else if (reg_addr == HIF_ADDR_FIFO_STAT2) begin
      rd_mux[HIF_STAT2_CNT_HI_LSB +: 2] = count[CW-1 -: 2];
      rd_mux[HIF_STAT2_UNF_BIT] = unf;
      rd_mux[HIF_STAT2_OVR_BIT] = ovr;
    end else if (reg_addr == HIF_ADDR_IO_CFG1) begin
      rd_mux = cfg1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      stop_all <= 1'b0;
      mcu_clk <= 1'b0;
      host_port_i2c <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      stop_all <= cmd_stop;
      mcu_clk <= next_mcu_clk;
      host_port_i2c <= pin_f[HIF_PIN_I2C_EN];
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_event_sets_bit: assert property ((ev[1] != 8'h00) |=> ((stat[1] & $past(ev[1])) == $past(ev[1])))
    else $error("timer event not recorded");
  a_irq_follows_pend: assert property ((|pend) |=> irq)
    else $error("irq not raised for pending bit");
  a_masked_quiet: assert property ((pend == 4'h0) |=> !irq)
    else $error("irq high with no unmasked bit");
  a_read_clears_main: assert property ((reg_rd && reg_addr == HIF_ADDR_IRQ_BASE && ev[0] == 8'h00)
    |=> (stat[0] == 8'h00) && (reg_rdata == $past(stat[0])))
    else $error("main status not returned and cleared");
  a_cmd_clears_all: assert property ((irq_clear_all && irq_events == '0)
    |=> (stat[0] | stat[1] | stat[2] | stat[3]) == 8'h00 ##1 !irq)
    else $error("command did not clear irq state");
  a_overflow_flag: assert property ((push_req && full && !fifo_reset) |=> ovr)
    else $error("overflow not flagged");
  a_underflow_flag: assert property ((pop_req && empty && !fifo_reset) |=> unf)
    else $error("underflow not flagged");
  a_empty_reads_zero: assert property ((fifo_host_rd && empty) |=> reg_rdata == 8'h00)
    else $error("empty fifo read not zero");
  a_fifo_reset_level: assert property (fifo_reset |=> (count == '0) && !ovr && !unf)
    else $error("fifo not reset");
  a_clock_off: assert property ((clk_sel == HIF_CLK_OFF) |=> !mcu_clk)
    else $error("clock output active while off");

  c_irq_read_drop: cover property (irq ##1 (reg_rd && in_irq) ##2 !irq);
  c_fifo_full: cover property (full);
  c_unmask_raise: cover property (($past(pend) == 4'h0) && (|pend) && !(|ev[0]));
  c_tx_pop: cover property (tx_pop && !empty);
endmodule
`default_nettype wire

/* File: design/hif_pkg.sv */
package hif_pkg;
  // ==========================================================
  // register bus
  localparam int HIF_AW = 6;
  localparam int HIF_DW = 8;
  localparam logic [HIF_AW-1:0] HIF_ADDR_IRQ_BASE = 6'h00;  // four status registers, 0x00..0x03
  localparam logic [HIF_AW-1:0] HIF_ADDR_MASK_BASE = 6'h04; // four mask registers, 0x04..0x07
  localparam logic [HIF_AW-1:0] HIF_ADDR_FIFO_DATA = 6'h08;
  localparam logic [HIF_AW-1:0] HIF_ADDR_FIFO_STAT1 = 6'h09;
  localparam logic [HIF_AW-1:0] HIF_ADDR_FIFO_STAT2 = 6'h0a;
  localparam logic [HIF_AW-1:0] HIF_ADDR_IO_CFG1 = 6'h0b;
  localparam logic [HIF_AW-1:0] HIF_ADDR_CMD = 6'h0c;
  // ==========================================================
  // direct commands written to the command register
  localparam logic [7:0] HIF_CMD_SET_DEFAULT = 8'hc1;
  localparam logic [7:0] HIF_CMD_STOP_ALL = 8'hc2;
  localparam logic [7:0] HIF_CMD_CLEAR_FIFO = 8'hc3;
  // ==========================================================
  // field positions and reset values
  localparam int HIF_STAT2_CNT_HI_LSB = 0;
  localparam int HIF_STAT2_UNF_BIT = 4;
  localparam int HIF_STAT2_OVR_BIT = 5;
  localparam int HIF_CFG1_OUTC_LSB = 0;
  localparam int HIF_CFG1_LFOFF_BIT = 2;
  localparam logic [7:0] HIF_CFG1_RST = 8'h01;  // 3.39 MHz selected, low clock enabled
  localparam logic [7:0] HIF_MASK_RST = 8'h00;
  localparam logic [7:0] HIF_STAT_RST = 8'h00;
  localparam int HIF_FIFO_DEPTH = 512;
  localparam int HIF_SYNC_STAGES = 3;
  // ==========================================================
  // clock output select, and index of each clock pin
  typedef enum logic [1:0] {
    HIF_CLK_OFF = 2'b00,
    HIF_CLK_3M39 = 2'b01,
    HIF_CLK_6M78 = 2'b10,
    HIF_CLK_13M56 = 2'b11
  } hif_clk_sel_t;
  localparam int HIF_PIN_3M39 = 0;
  localparam int HIF_PIN_6M78 = 1;
  localparam int HIF_PIN_13M56 = 2;
  localparam int HIF_PIN_LF = 3;
  localparam int HIF_PIN_I2C_EN = 4;
  localparam int HIF_NPINS = 5;
  // ==========================================================
  // interrupt events, one byte per source register
  typedef struct packed {
    logic [7:0] pt;
    logic [7:0] err;
    logic [7:0] timer;
    logic [7:0] main;
  } hif_irq_vec_t;
endpackage

/* File: test/hif_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// framing logic and oscillator taps on the far side of the block
module hif_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_req,
  input wire logic [7:0] rx_byte,
  input wire logic pop_req,
  input wire logic start_req,
  output logic rx_start,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_pop,
  output logic [3:0] osc_clk_pins
);
  logic [7:0] cnt;
  // taps {lf,13.56,6.78,3.39}; lf slowest so the gating is visible
  // fastest tap toggles every other cycle: a tap toggling each cycle never passes the agreement filter
  assign osc_clk_pins = {cnt[4], cnt[1], cnt[2], cnt[3]};
  // idle data bus inverts every cycle, alternating between the last byte and its inverse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      rx_start <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      tx_pop <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      rx_start <= start_req;
      rx_valid <= rx_req;
      rx_data <= rx_req ? rx_byte : ~rx_data;
      tx_pop <= pop_req;
    end
  end
endmodule
`default_nettype wire

/* File: test/test_host_irq_fifo_status.sv */
`timescale 1ns/1ps
`default_nettype none
module test_host_irq_fifo_status import hif_pkg::*; ;
  logic clk, rst_n, reg_wr, reg_rd, xtal_running, i2c_en_pin, rx_start, rx_valid, tx_pop;
  logic rx_req, pop_req, start_req, irq, stop_all, host_port_i2c, mcu_clk;
  logic [HIF_AW-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_byte, rx_data, tx_data, d, seed, q[$];
  logic [3:0] osc_clk_pins;
  hif_irq_vec_t irq_events;
  int fails, check_count, tog;
  hif_core dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_events(irq_events), .irq(irq), .rx_start(rx_start),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_pop(tx_pop), .tx_data(tx_data), .stop_all(stop_all),
    .xtal_running(xtal_running), .osc_clk_pins(osc_clk_pins), .i2c_en_pin(i2c_en_pin),
    .host_port_i2c(host_port_i2c), .mcu_clk(mcu_clk));
  hif_far_model far_u (.clk(clk), .rst_n(rst_n), .rx_req(rx_req), .rx_byte(rx_byte), .pop_req(pop_req),
    .start_req(start_req), .rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data), .tx_pop(tx_pop),
    .osc_clk_pins(osc_clk_pins));
  // ==========================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // host is the only initiator on the register port
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic ev(input int i, input logic [7:0] v);
    @(posedge clk);
    irq_events <= hif_irq_vec_t'(32'(v) << (8 * i));
    @(posedge clk);
    irq_events <= '0;
    cyc(2);
  endtask
  // clock output: count toggles of mcu_clk over 48 cycles, a whole number of half periods of every tap
  task automatic clk_run(input logic [7:0] cfg, input logic x, input int n);
    wr(HIF_ADDR_IO_CFG1, cfg);
    xtal_running <= x;
    cyc(10);
    tog = 0;
    repeat (48) begin
      d[0] = mcu_clk;
      cyc(1);
      tog += int'(d[0] != mcu_clk);
    end
    chk("mcu_clk", 16'(tog), 16'(n));
  endtask
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, xtal_running, i2c_en_pin, rx_req, pop_req, start_req} = '0;
    {reg_addr, reg_wdata, rx_byte} = '0;
    irq_events = '0;
    seed = 8'h4d;
    fails = 0;
    check_count = 0;
    cyc(6);
    rst_n = 1'b1;
    rd(HIF_ADDR_IO_CFG1);
    chk("io_cfg1", d, HIF_CFG1_RST);
    rd(6'h3f);
    chk("unmapped", d, 8'h00);
    // every source register: set, irq, read returns then clears
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      ev(i, seed | 8'h01);
      chk("irq set", irq, 1'b1);
      rd(HIF_ADDR_IRQ_BASE + 6'(i));
      chk("status", d, seed | 8'h01);
      cyc(2);
      chk("irq low", irq, 1'b0);
      rd(HIF_ADDR_IRQ_BASE + 6'(i));
      chk("cleared", d, 8'h00);
    end
    // masked source records but stays quiet until unmasked
    wr(HIF_ADDR_MASK_BASE + 6'h1, 8'hff);
    ev(1, 8'h24);
    chk("masked irq", irq, 1'b0);
    wr(HIF_ADDR_MASK_BASE + 6'h1, 8'hfb);
    cyc(2);
    chk("unmask irq", irq, 1'b1);
    rd(HIF_ADDR_IRQ_BASE + 6'h1);
    chk("masked read", d, 8'h24);
    wr(HIF_ADDR_MASK_BASE + 6'h1, 8'h00);
    // two pending sources: irq falls only after the last read
    ev(0, 8'h80);
    ev(2, 8'h02);
    rd(HIF_ADDR_IRQ_BASE);
    cyc(2);
    chk("irq held", irq, 1'b1);
    rd(HIF_ADDR_IRQ_BASE + 6'h2);
    cyc(2);
    chk("irq last", irq, 1'b0);
    // each clearing command
    for (int k = 0; k < 3; k++) begin
      wr(HIF_ADDR_IO_CFG1, 8'h07);
      ev(3, 8'h11);
      wr(HIF_ADDR_CMD, k == 0 ? HIF_CMD_SET_DEFAULT : k == 1 ? HIF_CMD_STOP_ALL : HIF_CMD_CLEAR_FIFO);
      #1 chk("stop_all", stop_all, 16'(k == 1));
      cyc(2);
      chk("cmd irq", irq, 1'b0);
      rd(HIF_ADDR_IRQ_BASE + 6'h3);
      chk("cmd status", d, 8'h00);
    end
    rd(HIF_ADDR_IO_CFG1);
    chk("cfg kept", d, 8'h07);
    wr(HIF_ADDR_CMD, HIF_CMD_SET_DEFAULT);
    rd(HIF_ADDR_IO_CFG1);
    chk("cfg default", d, HIF_CFG1_RST);
    // host pushes and pops random bytes, then framing pops
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      q.push_back(seed);
      wr(HIF_ADDR_FIFO_DATA, seed);
    end
    rd(HIF_ADDR_FIFO_STAT1);
    chk("count", d, 8'h05);
    for (int i = 0; i < 4; i++) begin
      rd(HIF_ADDR_FIFO_DATA);
      chk("fifo data", d, q.pop_front());
    end
    @(posedge clk) pop_req <= 1'b1;
    @(posedge clk) pop_req <= 1'b0;
    cyc(3);
    chk("tx_data", tx_data, q.pop_front());
    rd(HIF_ADDR_FIFO_DATA);
    chk("empty read", d, 8'h00);
    rd(HIF_ADDR_FIFO_STAT2);
    chk("underflow", d, 8'h10);
    wr(HIF_ADDR_CMD, HIF_CMD_CLEAR_FIFO);
    rd(HIF_ADDR_FIFO_STAT2);
    chk("flags reset", d, 8'h00);
    // reception fills past capacity by one byte
    // request and byte change together, so the first pushed byte is a fresh one
    for (int i = 0; i < HIF_FIFO_DEPTH + 1; i++) begin
      seed = lfsr(seed);
      @(posedge clk);
      rx_req <= 1'b1;
      rx_byte <= seed;
      if (i == 0) begin
        q.push_back(seed);
      end
    end
    @(posedge clk) rx_req <= 1'b0;
    cyc(2);
    rd(HIF_ADDR_FIFO_STAT2);
    chk("overflow", d, 8'h22);
    rd(HIF_ADDR_FIFO_DATA);
    chk("rx data", d, q.pop_front());
    @(posedge clk) start_req <= 1'b1;
    @(posedge clk) start_req <= 1'b0;
    cyc(2);
    rd(HIF_ADDR_FIFO_STAT2);
    chk("rx start", d, 8'h00);
    // clock output selections and the low clock gate
    clk_run(8'h00, 1'b1, 0);
    clk_run(8'h01, 1'b1, 6);
    clk_run(8'h02, 1'b1, 12);
    clk_run(8'h03, 1'b1, 24);
    clk_run(8'h01, 1'b0, 3);
    clk_run(8'h05, 1'b0, 0);
    // strap selects the host port
    i2c_en_pin <= 1'b1;
    cyc(8);
    chk("i2c port", host_port_i2c, 1'b1);
    i2c_en_pin <= 1'b0;
    cyc(8);
    chk("spi port", host_port_i2c, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
